/* File: bench/testbench.sv */
// self-checking bench for the status transfer and multiply unit
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic op_valid = 1'b0;
   psr_mul_pkg::op_kind_t op_kind = psr_mul_pkg::OP_STATUS_READ;
   logic [3:0] cond = 4'he;
   logic set_flags = 1'b0;
   logic saved_sel = 1'b0;
   logic flag_only = 1'b0;
   logic [31:0] operand_val = 32'h0;
   logic [31:0] multiplier_val = 32'h0;
   logic [31:0] accumulate_val = 32'h0;
   logic busy;
   logic done;
   logic result_we;
   logic [31:0] result;
   logic [31:0] current_status_word;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   integer seed = 32'h8dba19e9;
   logic [31:0] csw_m;
   logic [31:0] sav_m [5];
   logic [4:0] modes [6] = '{psr_mul_pkg::MODE_USER, psr_mul_pkg::MODE_FIQ,
      psr_mul_pkg::MODE_IRQ, psr_mul_pkg::MODE_SVC, psr_mul_pkg::MODE_ABT, psr_mul_pkg::MODE_UND};
   logic [31:0] mvals [10] = '{32'h0, 32'h1, 32'h2, 32'h7, 32'h8, 32'h1f, 32'h20,
      32'h1fff_ffff, 32'h2000_0000, 32'hffff_ffff};

   psr_mul_exec i_psr_mul_exec (.clk(clk), .arst_n(arst_n), .op_valid(op_valid),
      .op_kind(op_kind), .cond(cond), .set_flags(set_flags), .saved_sel(saved_sel),
      .flag_only(flag_only), .operand_val(operand_val), .multiplier_val(multiplier_val),
      .accumulate_val(accumulate_val), .busy(busy), .done(done), .result_we(result_we),
      .result(result), .current_status_word(current_status_word));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   // a hang must still reach the report
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic int slot(input logic [4:0] m);
      case (m)
         psr_mul_pkg::MODE_FIQ: return 0;
         psr_mul_pkg::MODE_IRQ: return 1;
         psr_mul_pkg::MODE_SVC: return 2;
         psr_mul_pkg::MODE_ABT: return 3;
         psr_mul_pkg::MODE_UND: return 4;
         default: return -1;
      endcase
   endfunction : slot

   function automatic int m_of(input logic [31:0] b);
      int h;
      h = 0;
      for (int i = 0; i < 32; i++)
         if (b[i])
            h = i;
      if (b < 32'h2)
         return 1;
      return ((h + 3) / 2 > 16) ? 16 : (h + 3) / 2;
   endfunction : m_of

   function automatic logic cond_ok(input logic [3:0] c, input logic [31:0] s);
      logic n, z, cf, v;
      {n, z, cf, v} = s[31:28];
      case (c)
         4'h0: return z;
         4'h1: return !z;
         4'h2: return cf;
         4'h3: return !cf;
         4'h4: return n;
         4'h5: return !n;
         4'h6: return v;
         4'h7: return !v;
         4'h8: return cf && !z;
         4'h9: return !cf || z;
         4'ha: return n == v;
         4'hb: return n != v;
         4'hc: return !z && (n == v);
         4'hd: return z || (n != v);
         4'he: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : cond_ok

   task automatic do_reset();
      arst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check(current_status_word, psr_mul_pkg::CUR_RESET);
      check(32'({busy, done, result_we}), 32'h0);
      check(result, 32'h0);
      arst_n = 1'b1;
      csw_m = psr_mul_pkg::CUR_RESET;
      foreach (sav_m[i])
         sav_m[i] = psr_mul_pkg::SAVED_RESET;
   endtask : do_reset

   task automatic do_op(input int k, input logic [3:0] cd, input logic sf, input logic sv,
      input logic fo, input logic [31:0] a, input logic [31:0] b, input logic [31:0] acc);
      int n, ec, sl;
      logic ewe;
      logic [31:0] er, p, old;
      old = csw_m;
      sl = slot(csw_m[4:0]);
      ec = 0;
      ewe = 1'b0;
      er = 32'h0;
      p = (k == 3) ? a * b + acc : a * b;
      if (cond_ok(cd, csw_m))
         case (k)
            0:
            begin
               ewe = 1'b1;
               er = sv ? ((sl < 0) ? 32'h0 : sav_m[sl]) : csw_m;
            end
            1:
            begin
               if (sv && sl >= 0)
                  sav_m[sl] = fo ? {a[31:28], sav_m[sl][27:0]} : a;
               else if (!sv && (fo || csw_m[4:0] == psr_mul_pkg::MODE_USER))
                  csw_m[31:28] = a[31:28];
               else if (!sv)
                  csw_m = a;
            end
            default:
            begin
               ec = m_of(b);
               ewe = 1'b1;
               er = p;
               if (sf)
                  csw_m[31:30] = {p[31], p == 32'h0};
            end
         endcase
      op_kind = psr_mul_pkg::op_kind_t'(k);
      {cond, set_flags, saved_sel, flag_only} = {cd, sf, sv, fo};
      {operand_val, multiplier_val, accumulate_val} = {a, b, acc};
      op_valid = 1'b1;
      @(posedge clk);
      #1;
      // a request held while busy must be ignored
      op_kind = psr_mul_pkg::OP_STATUS_WRITE;
      {cond, saved_sel, flag_only, operand_val} = {4'he, 1'b0, 1'b0, ~csw_m};
      n = 0;
      while (done !== 1'b1 && n < 40)
      begin
         check(32'(busy), 32'h1);
         check(current_status_word, old);
         @(posedge clk);
         #1;
         n++;
      end
      op_valid = 1'b0;
      check(32'(n), 32'(ec));
      check(32'(busy), 32'h0);
      check(32'(result_we), 32'(ewe));
      if (ewe)
         check(result, er);
      check(current_status_word, csw_m);
      @(posedge clk);
      #1;
      check(32'(done), 32'h0);
   endtask : do_op

   initial
   begin
      int k;
      logic sv;
      logic [31:0] a;
      logic [4:0] md;
      do_reset();
      do_op(1, 4'he, 0, 0, 1, 32'ha000_0000, 0, 0);
      do_op(1, 4'he, 0, 0, 1, 32'h5fff_ffff, 0, 0);
      for (int i = 1; i < 6; i++)
      begin
         // reserved bits written back as read
         do_op(1, 4'he, 0, 0, 0, {4'h5, 20'h0, 3'h6, modes[i]}, 0, 0);
         do_op(1, 4'he, 0, 1, 0, 32'h3000_00d0 ^ i, 0, 0);
         do_op(1, 4'he, 0, 1, 1, 32'hcfff_ffff, 0, 0);
         do_op(0, 4'he, 0, 1, 0, 0, 0, 0);
         do_op(0, 4'he, 0, 0, 0, 0, 0, 0);
      end
      do_op(1, 4'he, 0, 0, 0, {4'h0, 20'h0, 3'h6, psr_mul_pkg::MODE_USER}, 0, 0);
      do_op(1, 4'he, 0, 0, 0, {4'h9, 20'h0, 3'h6, psr_mul_pkg::MODE_SVC}, 0, 0);
      do_reset();
      for (int c = 0; c < 16; c++)
      begin
         do_op(1, 4'he, 0, 0, 1, 32'($random(seed)), 0, 0);
         do_op(2 + c % 2, c[3:0], 1, 0, 0, 32'($random(seed)), 32'h5, 32'h9);
      end
      foreach (mvals[i])
         do_op(2 + i % 2, 4'he, i % 3 != 0, 0, 0, 32'hffff_fff6 + i, mvals[i], ~mvals[i]);
      do_op(2, 4'he, 1, 0, 0, 32'hffff_fff6, 32'h14, 32'h7);
      do_op(3, 4'he, 1, 0, 0, 32'h0, 32'h1234, 32'h0);
      // accumulate and multiplier share one register value
      do_op(3, 4'he, 1, 0, 0, 32'h3, 32'h8000_0001, 32'h8000_0001);
      for (int i = 0; i < 300; i++)
      begin
         if (i % 50 == 49)
            do_reset();
         k = $random(seed) & 3;
         md = modes[($random(seed) & 32'h7fff_ffff) % 6];
         // no saved word is named in user mode
         sv = (csw_m[4:0] != psr_mul_pkg::MODE_USER) && $random(seed) & 1;
         // operands stand for registers other than the program counter, dest apart from source
         a = $random(seed);
         if (k == 1)
            a = {a[31:28], csw_m[27:8], a[7:6], csw_m[5], md};
         do_op(k, ($random(seed) & 3) ? 4'he : 4'($random(seed)), 1'($random(seed)), sv,
            1'($random(seed)), a, 32'($random(seed)) >> ($random(seed) & 31),
            32'($random(seed)));
      end
      conclude();
   end
endmodule : testbench

/* File: design/psr_mul_exec.sv */
// status word transfer and booth multiply execution unit
`timescale 1ns/10ps
// Operation
// RULE1: register flag write copies top four bits only
// RULE2: immediate flag write loads its top four bits
// RULE3: plain and whole selectors equal; flag selector restricts
// RULE4: user whole write changes only flag bits
// RULE5: privileged whole write replaces all 32 bits
// RULE6: status read copies all 32 bits out
// RULE7: saved writes go to current mode's slot
// RULE8: software never uses program counter here
// RULE9: radix-4 booth multiply, low 32 bits only
// RULE10: plain multiply ignores accumulate register
// RULE11: accumulate form adds accumulate register value
// RULE12: one datapath serves signed and unsigned
// RULE13: software avoids dest equal first source
// RULE14: any other register combination works correctly
// RULE15: flags change only when set-flags bit set
// RULE16: negative is bit 31, zero on zero result
// RULE17: carry unspecified, overflow kept
// RULE18: multiply costs one plus m internal cycles
// RULE19: multiplier range sets m internal cycles
// RULE20: values 0,1 take one; large take sixteen
// RULE21: failed condition means no effect at all
// RULE22: software never touches saved word in user
// RULE23: software preserves reserved bits on writes
// RULE24: commit product and flags after last cycle
module psr_mul_exec
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // instruction request
   input wire logic op_valid,
   input wire psr_mul_pkg::op_kind_t op_kind,
   input wire logic [3:0] cond,
   input wire logic set_flags,
   input wire logic saved_sel,
   input wire logic flag_only,
   // operands from the register bank (operand_val is first_source_reg or an expanded immediate)
   input wire logic [31:0] operand_val,
   input wire logic [31:0] multiplier_val,
   input wire logic [31:0] accumulate_val,
   // answer
   output logic busy,
   output logic done,
   output logic result_we,
   output logic [31:0] result,
   output logic [31:0] current_status_word
);

   logic [31:0] cur_r;
   logic [31:0] saved_r [psr_mul_pkg::SAVED_SLOTS];
   psr_mul_pkg::state_t state_r;
   logic busy_r;
   logic done_r;
   logic result_we_r;
   logic [31:0] result_r;
   logic [31:0] acc_r;
   logic [31:0] mcand_r;
   logic [32:0] mplier_r;
   logic [4:0] step_r;
   logic [4:0] steps_r;
   logic set_flags_r;
   logic accept;
   logic cond_ok;
   logic [2:0] slot;
   logic last_step;
   logic [31:0] pp;
   logic [31:0] booth_sum;

   function automatic logic cond_pass(input logic [3:0] c, input logic [31:0] w);
      logic n;
      logic z;
      logic cy;
      logic v;
      logic r;
      n = w[psr_mul_pkg::N_BIT];
      z = w[psr_mul_pkg::Z_BIT];
      cy = w[psr_mul_pkg::C_BIT];
      v = w[psr_mul_pkg::V_BIT];
      unique case (psr_mul_pkg::cond_t'(c))
         psr_mul_pkg::C_EQ: r = z;
         psr_mul_pkg::C_NE: r = !z;
         psr_mul_pkg::C_CS: r = cy;
         psr_mul_pkg::C_CC: r = !cy;
         psr_mul_pkg::C_MI: r = n;
         psr_mul_pkg::C_PL: r = !n;
         psr_mul_pkg::C_VS: r = v;
         psr_mul_pkg::C_VC: r = !v;
         psr_mul_pkg::C_HI: r = cy && !z;
         psr_mul_pkg::C_LS: r = !cy || z;
         psr_mul_pkg::C_GE: r = (n == v);
         psr_mul_pkg::C_LT: r = (n != v);
         psr_mul_pkg::C_GT: r = !z && (n == v);
         psr_mul_pkg::C_LE: r = z || (n != v);
         psr_mul_pkg::C_AL: r = 1'b1;
         psr_mul_pkg::C_NV: r = 1'b0;
      endcase
      return r;
   endfunction : cond_pass

   // saved word slot for a mode; user and unknown modes own none
   function automatic logic [2:0] mode_slot(input logic [4:0] m);
      logic [2:0] s;
      unique case (m)
         psr_mul_pkg::MODE_FIQ: s = 3'h0;
         psr_mul_pkg::MODE_IRQ: s = 3'h1;
         psr_mul_pkg::MODE_SVC: s = 3'h2;
         psr_mul_pkg::MODE_ABT: s = 3'h3;
         psr_mul_pkg::MODE_UND: s = 3'h4;
         default: s = psr_mul_pkg::SLOT_NONE;
      endcase
      return s;
   endfunction : mode_slot

   // internal cycles from the highest set multiplier bit
   function automatic logic [4:0] mul_cycles(input logic [31:0] b);
      int hi;
      int m;
      hi = -1;
      for (int i = 0; i < psr_mul_pkg::WORD_W; i++)
      begin
         if (b[i])
            hi = i;
      end
      m = (hi < 0) ? 1 : (hi + 3) / 2;
      if (m > psr_mul_pkg::MUL_MAX_CYC)
         m = psr_mul_pkg::MUL_MAX_CYC;
      return m[4:0];
   endfunction : mul_cycles

   assign accept = op_valid && !busy_r;
   assign cond_ok = cond_pass(cond, cur_r);
   assign slot = mode_slot(cur_r[psr_mul_pkg::MODE_W-1:0]);
   assign last_step = (step_r == steps_r - 5'h01);

   // booth digit from three multiplier bits; no sign control needed [RULE9] [RULE12]
   always_comb
   begin
      pp = 32'h0000_0000;
      unique case (mplier_r[2:0])
         3'b001, 3'b010: pp = mcand_r;
         3'b011: pp = {mcand_r[30:0], 1'b0};
         3'b100: pp = -{mcand_r[30:0], 1'b0};
         3'b101, 3'b110: pp = -mcand_r;
         default: pp = 32'h0000_0000;
      endcase
   end
   assign booth_sum = acc_r + pp;

   // sequencer: busy for exactly m internal cycles after the accept edge [RULE18] [RULE19] [RULE20]
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= psr_mul_pkg::ST_IDLE;
         busy_r <= 1'b0;
         step_r <= 5'h00;
         steps_r <= 5'h01;
      end
      else
      begin
         unique case (state_r)
            psr_mul_pkg::ST_IDLE:
            begin
               if (accept && cond_ok && op_kind[1])
               begin
                  state_r <= psr_mul_pkg::ST_MUL;
                  busy_r <= 1'b1;
                  step_r <= 5'h00;
                  steps_r <= mul_cycles(multiplier_val);
               end
            end
            psr_mul_pkg::ST_MUL:
            begin
               step_r <= step_r + 5'h01;
               if (last_step)
               begin
                  state_r <= psr_mul_pkg::ST_IDLE;
                  busy_r <= 1'b0;
               end
            end
         endcase
      end
   end

   // booth datapath; operands are latched so dest may alias any source [RULE14]
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         acc_r <= 32'h0000_0000;
         mcand_r <= 32'h0000_0000;
         mplier_r <= 33'h0_0000_0000;
         set_flags_r <= 1'b0;
      end
      else if (accept && op_kind[1])
      begin
         // plain form starts from zero, accumulate form from its register [RULE10] [RULE11]
         acc_r <= (op_kind == psr_mul_pkg::OP_MULTIPLY_ACC) ? accumulate_val : 32'h0000_0000;
         mcand_r <= operand_val;
         mplier_r <= {multiplier_val, 1'b0};
         set_flags_r <= set_flags;
      end
      else if (state_r == psr_mul_pkg::ST_MUL)
      begin
         acc_r <= booth_sum;
         mcand_r <= {mcand_r[29:0], 2'b00};
         mplier_r <= {2'b00, mplier_r[32:2]};
      end
   end

   // answer registers; a failed condition still answers, with no write [RULE21]
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         done_r <= 1'b0;
         result_we_r <= 1'b0;
         result_r <= 32'h0000_0000;
      end
      else
      begin
         done_r <= 1'b0;
         result_we_r <= 1'b0;
         if (state_r == psr_mul_pkg::ST_MUL && last_step)
         begin
            done_r <= 1'b1;
            result_we_r <= 1'b1;
            result_r <= booth_sum; // [RULE24]
         end
         else if (accept && !(cond_ok && op_kind[1]))
         begin
            done_r <= 1'b1;
            if (cond_ok && op_kind == psr_mul_pkg::OP_STATUS_READ)
            begin
               result_we_r <= 1'b1;
               // user mode has no saved word: reads as zero
               result_r <= !saved_sel ? cur_r :
                  (slot == psr_mul_pkg::SLOT_NONE) ? 32'h0000_0000 : saved_r[slot]; // [RULE6]
            end
         end
      end
   end

   // current status word: transfers and multiply flag updates
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cur_r <= psr_mul_pkg::CUR_RESET;
      else if (state_r == psr_mul_pkg::ST_MUL && last_step && set_flags_r) // [RULE15]
      begin
         // carry left as it was, which is one allowed meaningless value [RULE17]
         cur_r[psr_mul_pkg::N_BIT] <= booth_sum[31]; // [RULE16]
         cur_r[psr_mul_pkg::Z_BIT] <= (booth_sum == 32'h0000_0000); // [RULE16]
      end
      else if (accept && cond_ok && op_kind == psr_mul_pkg::OP_STATUS_WRITE && !saved_sel)
      begin
         if (flag_only || cur_r[psr_mul_pkg::MODE_W-1:0] == psr_mul_pkg::MODE_USER)
            cur_r[psr_mul_pkg::FLAG_HI:psr_mul_pkg::FLAG_LO] <=
               operand_val[psr_mul_pkg::FLAG_HI:psr_mul_pkg::FLAG_LO]; // [RULE1] [RULE2] [RULE4]
         else
            cur_r <= operand_val; // [RULE3] [RULE5]
      end
   end

   // saved status words, one per privileged mode; writes in user mode are dropped
   generate
      for (genvar g = 0; g < psr_mul_pkg::SAVED_SLOTS; g++)
      begin : g_saved
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               saved_r[g] <= psr_mul_pkg::SAVED_RESET;
            else if (accept && cond_ok && op_kind == psr_mul_pkg::OP_STATUS_WRITE && saved_sel
                     && slot == 3'(g)) // [RULE7]
            begin
               if (flag_only)
                  saved_r[g][psr_mul_pkg::FLAG_HI:psr_mul_pkg::FLAG_LO] <=
                     operand_val[psr_mul_pkg::FLAG_HI:psr_mul_pkg::FLAG_LO]; // [RULE3]
               else
                  saved_r[g] <= operand_val; // [RULE7]
            end
         end
      end
   endgenerate

   assign busy = busy_r;
   assign done = done_r;
   assign result_we = result_we_r;
   assign result = result_r;
   assign current_status_word = cur_r;

   // checking helpers: operands and expected cycle count of the running multiply
   logic [31:0] chk_a_r;
   logic [31:0] chk_b_r;
   logic [31:0] chk_c_r;
   logic [4:0] chk_m_r;
   logic [4:0] chk_cnt_r;
   logic chk_mul_r;
   logic [31:0] chk_cur_r;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         chk_a_r <= 32'h0000_0000;
         chk_b_r <= 32'h0000_0000;
         chk_c_r <= 32'h0000_0000;
         chk_m_r <= 5'h00;
         chk_cnt_r <= 5'h00;
         chk_mul_r <= 1'b0;
         chk_cur_r <= 32'h0000_0000;
      end
      else if (accept)
      begin
         chk_a_r <= operand_val;
         chk_b_r <= multiplier_val;
         chk_c_r <= (op_kind == psr_mul_pkg::OP_MULTIPLY_ACC) ? accumulate_val : 32'h0000_0000;
         chk_m_r <= mul_cycles(multiplier_val);
         chk_cnt_r <= 5'h00;
         chk_mul_r <= cond_ok && op_kind[1];
         chk_cur_r <= cur_r;
      end
      else if (state_r == psr_mul_pkg::ST_MUL)
         chk_cnt_r <= chk_cnt_r + 5'h01;
   end

   flag_write_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE1]
      accept && cond_ok && op_kind == psr_mul_pkg::OP_STATUS_WRITE && !saved_sel && flag_only
      |=> cur_r[31:28] == $past(operand_val[31:28]) && cur_r[27:0] == $past(cur_r[27:0]))
      else $error("flag-only write disturbed control bits");
   user_protect_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
      accept && cond_ok && op_kind == psr_mul_pkg::OP_STATUS_WRITE && !saved_sel
      && cur_r[4:0] == psr_mul_pkg::MODE_USER
      |=> cur_r[27:0] == $past(cur_r[27:0]))
      else $error("user mode changed control bits");
   priv_whole_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
      accept && cond_ok && op_kind == psr_mul_pkg::OP_STATUS_WRITE && !saved_sel && !flag_only
      && cur_r[4:0] != psr_mul_pkg::MODE_USER
      |=> cur_r == $past(operand_val))
      else $error("privileged whole write not taken");
   read_copy_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE6]
      accept && cond_ok && op_kind == psr_mul_pkg::OP_STATUS_READ && !saved_sel
      |=> done_r && result_we_r && result_r == $past(cur_r))
      else $error("status read returned wrong word");
   saved_write_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE7]
      accept && cond_ok && op_kind == psr_mul_pkg::OP_STATUS_WRITE && saved_sel && !flag_only
      && slot != psr_mul_pkg::SLOT_NONE
      |=> saved_r[$past(slot)] == $past(operand_val) && cur_r == $past(cur_r))
      else $error("saved word write went astray");
   mul_value_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE11]
      done_r && chk_mul_r |-> result_we_r && result_r == 32'(chk_a_r * chk_b_r + chk_c_r))
      else $error("multiply result wrong");
   mul_cycles_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE19]
      done_r && chk_mul_r |-> chk_cnt_r == chk_m_r && !busy_r)
      else $error("multiply took wrong cycle count");
   mul_flags_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE16]
      done_r && chk_mul_r && set_flags_r
      |-> cur_r[31] == result_r[31] && cur_r[30] == (result_r == 32'h0000_0000)
      && cur_r[28] == chk_cur_r[28])
      else $error("multiply flags wrong");
   mul_noflag_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE15]
      done_r && chk_mul_r && !set_flags_r |-> cur_r == chk_cur_r)
      else $error("multiply changed flags without request");
   cond_skip_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE21]
      accept && !cond_ok |=> done_r && !result_we_r && !busy_r && cur_r == $past(cur_r))
      else $error("failed condition had an effect");

endmodule : psr_mul_exec

/* File: design/psr_mul_pkg.sv */
// constants and types for the status transfer and multiply execution block
package psr_mul_pkg;
   localparam int WORD_W = 32;
   localparam int N_BIT = 31;
   localparam int Z_BIT = 30;
   localparam int C_BIT = 29;
   localparam int V_BIT = 28;
   localparam int FLAG_HI = 31;
   localparam int FLAG_LO = 28;
   localparam int MODE_W = 5;
   localparam logic [4:0] MODE_USER = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1b;
   localparam int SAVED_SLOTS = 5;
   localparam int SLOT_W = 3;
   localparam logic [2:0] SLOT_NONE = 3'h7;
   localparam logic [31:0] CUR_RESET = 32'h0000_00d3;
   localparam logic [31:0] SAVED_RESET = 32'h0000_0000;
   localparam int MUL_MAX_CYC = 16;
   localparam int CYC_W = 5;

   typedef enum logic [1:0] {
      OP_STATUS_READ = 2'h0,
      OP_STATUS_WRITE = 2'h1,
      OP_MULTIPLY = 2'h2,
      OP_MULTIPLY_ACC = 2'h3
   } op_kind_t;

   typedef enum logic [3:0] {
      C_EQ = 4'h0, C_NE = 4'h1, C_CS = 4'h2, C_CC = 4'h3,
      C_MI = 4'h4, C_PL = 4'h5, C_VS = 4'h6, C_VC = 4'h7,
      C_HI = 4'h8, C_LS = 4'h9, C_GE = 4'ha, C_LT = 4'hb,
      C_GT = 4'hc, C_LE = 4'hd, C_AL = 4'he, C_NV = 4'hf
   } cond_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_MUL = 2'b10
   } state_t;
endpackage : psr_mul_pkg
